// ---- design/l2ap_core.sv ----
// l2ap_core: l2 lookup, allocation policy, miss tracking and memory command issue
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - eight ways, pseudo-lru victim choice
// - line size 32 or 64 bytes
// - only legal sets per way geometries
// - 32K and 64K need 64B, no ECC
// - disabled cache behaves as pure pass-through
// - memory port 64/128/256 bits, 64B lines
// - line burst eight, four or two beats
// - RAM stalls 0..3 stretch accesses
// - ECC coverage per array when configured; here ECC_EN only enters the geometry check and the status register
// - outstanding read misses limited, out of order
// - seven stages, eighth for pipelined RAMs
// - hint used only with 32B lines
// - hint zero: read allocates only with 64B lines, write only on io partial request
// - full-line write hit, write-back or coherent: overwrite, dirty, silent
// - full-line write miss allocates per hint
// - write-through miss never allocates, partial only on io request
// - io partial-allocate writes are allocated when write-back or coherent and an unlocked way is free
// - merge write data into pending fill
// - only write-back or coherent writes allocate
// - read hit returns data, line stays
// - read miss fetches, allocates per hint
// - bypass sends everything straight to memory
// - cache type zero means write-through
module l2ap_core import l2ap_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // requester side
  input wire logic req_valid,
  input wire l2ap_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output l2ap_rsp_t rsp,
  // memory side
  output logic mem_cmd_valid,
  output l2ap_mcmd_t mem_cmd,
  input wire logic mem_cmd_accept,
  input wire logic mem_rsp_valid,
  input wire logic [MIDX_BITS-1:0] mem_rsp_tag
);
  localparam logic CFG_OK = cfg_legal(LINE_BYTES, SETS, ECC_EN, MISS_MAX, MEM_DW);

  l2ap_state_t state_q;
  l2ap_req_t cur_q;
  l2ap_mcmd_t mem_cmd_q;
  l2ap_mcmd_t main_cmd_q;
  l2ap_mcmd_t main_cmd;
  l2ap_rsp_t rsp_q;
  l2ap_miss_t miss_q [MISS_MAX];
  l2ap_miss_t fill_e;
  logic [TAG_BITS-1:0] tag_q [SETS][WAYS];
  logic [WAYS-1:0] valid_q [SETS];
  logic [WAYS-1:0] dirty_q [SETS];
  logic [WAYS-1:0] pend_q [SETS];
  logic [PLRU_BITS-1:0] plru_q [SETS];
  logic [31:0] ctrl_q, hits_q, misses_q, prdata_q, status;
  logic pready_q, pslverr_q, req_ready_q, mem_cmd_valid_q, rsp_valid_q;
  logic [3:0] look_cnt_q, look_len_q;
  logic [1:0] data_cnt_q;
  logic act_memrd_q, act_memwr_q, act_rsp_q, act_hit_q, act_alloc_q;
  logic [SET_BITS-1:0] cur_set, fill_set;
  logic [TAG_BITS-1:0] cur_tag;
  logic [LINE_BITS-1:0] cur_line;
  logic [WAYS-1:0] hit_vec, lock;
  logic [WAY_BITS-1:0] hit_way, victim;
  logic [MIDX_BITS-1:0] free_idx, pend_idx;
  logic [MIDX_BITS:0] out_cnt;
  logic [2:0] eff_cca;
  logic [1:0] tstall, dstall, wstall, half_bit;
  logic bypass_eff, is_wb, cacheable, eff_hint, d_hit, any_free, alloc_ok;
  logic have_free, pend_hit, dec_fire, fill_ok, fill_rsp, line_sized;
  logic d_memrd, d_memwr, d_rsp, d_data, d_alloc, d_merge, d_evict;

  assign tstall = ctrl_q[CTRL_TSTALL_LSB +: 2];
  assign dstall = ctrl_q[CTRL_DSTALL_LSB +: 2];
  assign wstall = ctrl_q[CTRL_WSTALL_LSB +: 2];
  assign lock = ctrl_q[CTRL_LOCK_LSB +: WAYS];
  // a cache built without storage only passes requests on
  assign bypass_eff = ctrl_q[CTRL_BYPASS] | ~L2_ENABLE;
  // override applied before any policy decision
  assign eff_cca = ctrl_q[CTRL_OVR_EN] ? ctrl_q[CTRL_OVR_LSB +: 3] : cur_q.request_cache_type;
  assign is_wb = eff_cca == CCA_WB || eff_cca == CCA_CWBE || eff_cca == CCA_CWB;
  assign cacheable = is_wb || eff_cca == CCA_WT;
  assign eff_hint = LINE64 ? 1'b0 : cur_q.core_alloc_hint;
  assign cur_set = cur_q.addr[OFF_BITS +: SET_BITS];
  assign cur_tag = cur_q.addr[31 -: TAG_BITS];
  assign cur_line = cur_q.addr[31 -: LINE_BITS];
  assign half_bit = cur_q.addr[OFF_BITS-1] ? 2'b10 : 2'b01;
  assign dec_fire = state_q == S_LOOK && look_cnt_q == '0;
  assign fill_e = miss_q[mem_rsp_tag[2:0]];
  assign fill_set = fill_e.line[SET_BITS-1:0];
  assign fill_ok = mem_rsp_valid && fill_e.valid;
  assign fill_rsp = fill_ok && fill_e.rsp;
  assign d_hit = |hit_vec;
  assign alloc_ok = any_free && !pend_q[cur_set][victim] && !pend_hit;
  assign d_evict = d_alloc && valid_q[cur_set][victim] && dirty_q[cur_set][victim];

  for (genvar w = 0; w < WAYS; w++) begin : g_way
    assign hit_vec[w] = valid_q[cur_set][w] && tag_q[cur_set][w] == cur_tag;
  end

  l2ap_plru l2ap_plru_i (
    .tree(plru_q[cur_set]),
    .lock(lock),
    .victim(victim),
    .any_free(any_free)
  );

  always_comb begin
    hit_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (hit_vec[w]) begin
        hit_way = WAY_BITS'(w);
      end
    end
  end

  always_comb begin
    have_free = 1'b0;
    free_idx = '0;
    pend_hit = 1'b0;
    pend_idx = '0;
    out_cnt = '0;
    for (int i = MISS_MAX - 1; i >= 0; i--) begin
      if (!miss_q[i].valid) begin
        have_free = 1'b1;
        free_idx = MIDX_BITS'(i);
      end else if (miss_q[i].line == cur_line) begin
        pend_hit = 1'b1;
        pend_idx = MIDX_BITS'(i);
      end
      out_cnt = out_cnt + {{MIDX_BITS{1'b0}}, miss_q[i].valid};
    end
  end

  always_comb begin
    d_memrd = 1'b0;
    d_memwr = 1'b0;
    d_rsp = 1'b0;
    d_data = 1'b0;
    d_alloc = 1'b0;
    d_merge = 1'b0;
    if (bypass_eff || !cacheable) begin
      d_memrd = !cur_q.write;
      d_memwr = cur_q.write;
      d_rsp = cur_q.write;
    end else if (cur_q.write && pend_hit && miss_q[pend_idx[2:0]].alloc) begin
      d_merge = 1'b1;
      d_rsp = 1'b1;
    end else if (d_hit) begin
      d_data = 1'b1;
      d_rsp = 1'b1;
      d_memwr = cur_q.write && eff_cca == CCA_WT;
    end else if (!cur_q.write) begin
      d_memrd = 1'b1;
      d_alloc = (LINE64 || eff_hint) && alloc_ok;
    end else begin
      d_alloc = ((cur_q.full_line && eff_hint) ||
                 (cur_q.from_io && cur_q.io_partial_alloc_req)) && is_wb && alloc_ok;
      d_memrd = d_alloc && !cur_q.full_line;
      d_memwr = !d_alloc;
      d_rsp = 1'b1;
    end
  end

  always_comb begin
    line_sized = (cur_q.write && !d_memrd) ? cur_q.full_line : !bypass_eff && cacheable;
    main_cmd.addr = line_sized ? {cur_q.addr[31:OCP_OFF], {OCP_OFF{1'b0}}} : cur_q.addr;
    main_cmd.write = !d_memrd;
    main_cmd.beats = line_sized ? BURST_BEATS : SINGLE_BEAT;
    main_cmd.tag = free_idx;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      req_ready_q <= 1'b0;
      cur_q <= '0;
      look_cnt_q <= '0;
      data_cnt_q <= '0;
      act_memrd_q <= 1'b0;
      act_memwr_q <= 1'b0;
      act_rsp_q <= 1'b0;
      act_hit_q <= 1'b0;
      act_alloc_q <= 1'b0;
      main_cmd_q <= '0;
      mem_cmd_q <= '0;
      mem_cmd_valid_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (req_valid && req_ready_q) begin
            cur_q <= req;
            req_ready_q <= 1'b0;
            look_cnt_q <= LOOK_BASE + 4'(tstall) + 4'(wstall) - 4'h1;
            state_q <= S_LOOK;
          end else begin
            req_ready_q <= have_free;
          end
        end
        S_LOOK: begin
          if (look_cnt_q != '0) begin
            look_cnt_q <= look_cnt_q - 4'h1;
          end else begin
            act_memrd_q <= d_memrd;
            act_memwr_q <= d_memwr;
            act_rsp_q <= d_rsp;
            act_hit_q <= d_hit && d_data;
            act_alloc_q <= d_alloc;
            main_cmd_q <= main_cmd;
            if (d_data) begin
              data_cnt_q <= dstall;
              state_q <= S_DATA;
            end else if (d_evict) begin
              mem_cmd_q <= '{addr: {tag_q[cur_set][victim], cur_set, {OFF_BITS{1'b0}}},
                             write: 1'b1, beats: BURST_BEATS, tag: '0};
              mem_cmd_valid_q <= 1'b1;
              state_q <= S_EVICT;
            end else if (d_memrd || d_memwr) begin
              mem_cmd_q <= main_cmd;
              mem_cmd_valid_q <= 1'b1;
              state_q <= S_MREQ;
            end else begin
              state_q <= d_rsp ? S_RESP : S_IDLE;
            end
          end
        end
        S_DATA: begin
          if (data_cnt_q != '0) begin
            data_cnt_q <= data_cnt_q - 2'h1;
          end else if (act_memwr_q) begin
            mem_cmd_q <= main_cmd_q;
            mem_cmd_valid_q <= 1'b1;
            state_q <= S_MREQ;
          end else begin
            state_q <= S_RESP;
          end
        end
        S_EVICT: begin
          if (mem_cmd_accept) begin
            if (act_memrd_q || act_memwr_q) begin
              mem_cmd_q <= main_cmd_q;
              state_q <= S_MREQ;
            end else begin
              mem_cmd_valid_q <= 1'b0;
              state_q <= act_rsp_q ? S_RESP : S_IDLE;
            end
          end
        end
        S_MREQ: begin
          if (mem_cmd_accept) begin
            mem_cmd_valid_q <= 1'b0;
            state_q <= act_rsp_q ? S_RESP : S_IDLE;
          end
        end
        S_RESP: begin
          // a fill owns the response slot this cycle
          if (!fill_rsp) begin
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // out-of-order fills answer by table entry
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_valid_q <= fill_rsp || state_q == S_RESP;
      if (fill_rsp) begin
        rsp_q <= '{id: fill_e.id, hit: 1'b0, alloc: fill_e.alloc, mem_dropped: &fill_e.mask};
      end else if (state_q == S_RESP) begin
        rsp_q <= '{id: cur_q.id, hit: act_hit_q, alloc: act_alloc_q, mem_dropped: 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < MISS_MAX; i++) begin
        miss_q[i] <= '0;
      end
    end else begin
      if (fill_ok) begin
        miss_q[mem_rsp_tag[2:0]].valid <= 1'b0;
      end
      if (dec_fire && d_memrd) begin
        miss_q[free_idx[2:0]] <= '{valid: 1'b1, line: cur_line, way: victim, alloc: d_alloc,
                                   rsp: !cur_q.write, mask: cur_q.write ? half_bit : 2'b00,
                                   id: cur_q.id};
      end
      // both halves written means memory data is dropped
      if (dec_fire && d_merge) begin
        miss_q[pend_idx[2:0]].mask <= miss_q[pend_idx[2:0]].mask | half_bit;
      end
    end
  end

  // tag storage needs no reset, valid bits guard it
  always_ff @(posedge core_clk) begin
    if (dec_fire && d_alloc) begin
      tag_q[cur_set][victim] <= cur_tag;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int s = 0; s < SETS; s++) begin
        valid_q[s] <= '0;
        dirty_q[s] <= '0;
        pend_q[s] <= '0;
        plru_q[s] <= '0;
      end
    end else begin
      if (fill_ok && fill_e.alloc) begin
        valid_q[fill_set][fill_e.way] <= 1'b1;
        pend_q[fill_set][fill_e.way] <= 1'b0;
        dirty_q[fill_set][fill_e.way] <= |fill_e.mask;
        plru_q[fill_set] <= plru_touch(plru_q[fill_set], fill_e.way);
      end
      if (dec_fire && d_alloc) begin
        valid_q[cur_set][victim] <= !d_memrd;
        pend_q[cur_set][victim] <= d_memrd;
        dirty_q[cur_set][victim] <= cur_q.write && !d_memrd;
        plru_q[cur_set] <= plru_touch(plru_q[cur_set], victim);
      end else if (dec_fire && d_data) begin
        if (cur_q.write && is_wb) begin
          dirty_q[cur_set][hit_way] <= 1'b1;
        end
        plru_q[cur_set] <= plru_touch(plru_q[cur_set], hit_way);
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hits_q <= '0;
      misses_q <= '0;
    end else if (dec_fire && cacheable && !bypass_eff) begin
      if (d_hit) begin
        hits_q <= hits_q + 32'h0000_0001;
      end else begin
        misses_q <= misses_q + 32'h0000_0001;
      end
    end
  end

  assign status = {21'h0_0000, ECC_EN, LINE64, CFG_OK, 3'h0, out_cnt};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q) begin
        pslverr_q <= !(paddr == REG_CTRL || paddr == REG_STATUS ||
                       paddr == REG_HITS || paddr == REG_MISSES);
        unique case (paddr)
          REG_CTRL: prdata_q <= ctrl_q;
          REG_STATUS: prdata_q <= status;
          REG_HITS: prdata_q <= hits_q;
          REG_MISSES: prdata_q <= misses_q;
          default: prdata_q <= '0;
        endcase
      end
      if (psel && penable && pready_q && pwrite && paddr == REG_CTRL) begin
        ctrl_q <= pwdata & CTRL_MASK;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign req_ready = req_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign mem_cmd_valid = mem_cmd_valid_q;
  assign mem_cmd = mem_cmd_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      look_len_q <= '0;
    end else begin
      look_len_q <= (state_q == S_LOOK && !dec_fire) ? look_len_q + 4'h1 : 4'h0;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_out_limit: assert property (req_ready_q |-> have_free && out_cnt < 5'(MISS_MAX))
    else $error("request taken with miss table full");
  a_look_len: assert property (dec_fire |-> look_len_q + 4'h1 == LOOK_BASE + 4'(tstall) + 4'(wstall))
    else $error("lookup length does not match stalls");
  a_hint_zero: assert property (dec_fire && LINE64 && !cur_q.write |-> d_hit || d_alloc || pend_hit || !alloc_ok || bypass_eff || !cacheable)
    else $error("read miss not allocated with 64-byte lines");
  a_evict_burst: assert property (state_q == S_EVICT && mem_cmd_valid_q |-> mem_cmd_q.write && mem_cmd_q.beats == BURST_BEATS)
    else $error("eviction not a full line burst");
  a_cmd_hold: assert property (mem_cmd_valid_q && !mem_cmd_accept |=> mem_cmd_valid_q && $stable(mem_cmd_q))
    else $error("memory command changed before accept");
  a_wt_noalloc: assert property (dec_fire && cur_q.write && eff_cca == CCA_WT |-> !d_alloc)
    else $error("write-through write allocated");
  a_full_hit: assert property (dec_fire && d_data && cur_q.write && cur_q.full_line && is_wb |-> !d_memwr ##1 state_q == S_DATA)
    else $error("full-line write hit reached memory");
  a_bypass_route: assert property (dec_fire && bypass_eff |-> !d_alloc && !d_data && (d_memrd || d_memwr))
    else $error("bypass request touched the arrays");
  a_read_hit: assert property (dec_fire && d_data && !cur_q.write |-> ##[2:12] rsp_valid_q && rsp_q.hit)
    else $error("read hit not answered");
  a_victim_lock: assert property (dec_fire && d_alloc |-> !lock[victim])
    else $error("locked way chosen as victim");

  c_fill_alloc: cover property (fill_rsp && fill_e.alloc);
  c_merge_drop: cover property (fill_ok && &fill_e.mask);
  c_evict: cover property (state_q == S_EVICT && mem_cmd_accept);
endmodule // l2ap_core
`default_nettype wire

// ---- shared/l2ap_pkg.sv ----
// l2ap_pkg: geometry, codes, register map and types of the l2 allocation controller
package l2ap_pkg;
  localparam int WAYS = 8;
  localparam int LINE_BYTES = 64;
  localparam int SETS = 64;
  localparam logic ECC_EN = 1'b0;
  localparam logic L2_ENABLE = 1'b1;
  localparam logic PIPE_RAMS = 1'b0;
  localparam int MISS_MAX = 8;
  localparam int MEM_DW = 64;
  localparam int OCP_LINE = 64;
  localparam int PIPE_STAGES = 7 + int'(PIPE_RAMS);
  localparam int OFF_BITS = $clog2(LINE_BYTES);
  localparam int OCP_OFF = $clog2(OCP_LINE);
  localparam int SET_BITS = $clog2(SETS);
  localparam int TAG_BITS = 32 - OFF_BITS - SET_BITS;
  localparam int LINE_BITS = 32 - OFF_BITS;
  localparam int MIDX_BITS = 4;
  localparam int WAY_BITS = 3;
  localparam int PLRU_BITS = WAYS - 1;
  localparam logic LINE64 = (LINE_BYTES == 64);
  localparam logic [3:0] BURST_BEATS = 4'(OCP_LINE * 8 / MEM_DW);
  localparam logic [3:0] SINGLE_BEAT = 4'h1;
  // lookup stages ahead of the data stage and response
  localparam logic [3:0] LOOK_BASE = 4'(PIPE_STAGES - 4);
  // legal geometry limits
  localparam int SETS32_MIN = 512;
  localparam int SETS32_MAX = 32768;
  localparam int SETS64_MIN = 64;
  localparam int SETS64_MAX = 16384;
  localparam int SETS64_ECC_MIN = 512;
  // request cache types
  localparam logic [2:0] CCA_WT = 3'h0;
  localparam logic [2:0] CCA_WB = 3'h3;
  localparam logic [2:0] CCA_CWBE = 3'h4;
  localparam logic [2:0] CCA_CWB = 3'h5;
  // register map and fields
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_HITS = 12'h008;
  localparam logic [11:0] REG_MISSES = 12'h00c;
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_OVR_EN = 1;
  localparam int CTRL_OVR_LSB = 2;
  localparam int CTRL_TSTALL_LSB = 8;
  localparam int CTRL_DSTALL_LSB = 10;
  localparam int CTRL_WSTALL_LSB = 12;
  localparam int CTRL_LOCK_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h00ff_3f1f;

  function automatic logic cfg_legal(int line, int sets, logic ecc, int miss, int dw);
    logic ok;
    ok = (sets & (sets - 1)) == 0;
    ok = ok && (miss == 8 || miss == 12 || miss == 15);
    ok = ok && (dw == 64 || dw == 128 || dw == 256);
    if (line == 32) begin
      return ok && sets >= SETS32_MIN && sets <= SETS32_MAX;
    end
    // the smallest 64-byte geometries have no room for check bits
    return ok && line == 64 && sets >= SETS64_MIN && sets <= SETS64_MAX
           && !(ecc && sets < SETS64_ECC_MIN);
  endfunction

  function automatic logic [PLRU_BITS-1:0] plru_touch(logic [PLRU_BITS-1:0] t,
                                                      logic [WAY_BITS-1:0] w);
    logic [PLRU_BITS-1:0] n;
    n = t;
    n[0] = ~w[2];
    n[3'd1 + {2'b00, w[2]}] = ~w[1];
    n[3'd3 + {1'b0, w[2:1]}] = ~w[0];
    return n;
  endfunction

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic full_line;
    logic [2:0] request_cache_type;
    logic core_alloc_hint;
    logic from_io;
    logic io_partial_alloc_req;
    logic [3:0] id;
  } l2ap_req_t;

  typedef struct packed {
    logic [3:0] id;
    logic hit;
    logic alloc;
    logic mem_dropped;
  } l2ap_rsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [3:0] beats;
    logic [MIDX_BITS-1:0] tag;
  } l2ap_mcmd_t;

  typedef struct packed {
    logic valid;
    logic [LINE_BITS-1:0] line;
    logic [WAY_BITS-1:0] way;
    logic alloc;
    logic rsp;
    logic [1:0] mask;
    logic [3:0] id;
  } l2ap_miss_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_LOOK = 6'h02,
    S_DATA = 6'h04,
    S_EVICT = 6'h08,
    S_MREQ = 6'h10,
    S_RESP = 6'h20
  } l2ap_state_t;
endpackage

// ---- design/l2ap_plru.sv ----
// l2ap_plru: tree pseudo-lru victim choice that steers around locked ways
`timescale 1ns/100ps
`default_nettype none
module l2ap_plru import l2ap_pkg::*; (
  // tree state and locked ways
  input wire logic [PLRU_BITS-1:0] tree,
  input wire logic [WAYS-1:0] lock,
  // chosen way
  output logic [WAY_BITS-1:0] victim,
  output logic any_free
);
  function automatic logic steer(logic b, logic l_ok, logic r_ok);
    return !l_ok ? 1'b1 : (!r_ok ? 1'b0 : b);
  endfunction

  logic [WAYS-1:0] avail;
  logic [3:0] half;
  logic [1:0] quarter;
  logic d0;
  logic d1;
  logic d2;

  assign avail = ~lock;
  assign any_free = |avail;
  assign d0 = steer(tree[0], |avail[3:0], |avail[7:4]);
  assign half = d0 ? avail[7:4] : avail[3:0];
  assign d1 = steer(d0 ? tree[2] : tree[1], |half[1:0], |half[3:2]);
  assign quarter = d1 ? half[3:2] : half[1:0];
  assign d2 = steer(tree[3'd3 + {1'b0, d0, d1}], quarter[0], quarter[1]);
  assign victim = {d0, d1, d2};
endmodule // l2ap_plru
`default_nettype wire

// ---- testbench/l2ap_mem_model.sv ----
// l2ap_mem_model: main memory behind the line port, takes commands and returns read fills
`timescale 1ns/100ps
`default_nettype none
module l2ap_mem_model import l2ap_pkg::*; (
  // clock, reset and pacing
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  // command and fill
  input wire logic mem_cmd_valid,
  input wire l2ap_mcmd_t mem_cmd,
  output logic mem_cmd_accept,
  output logic mem_rsp_valid,
  output logic [MIDX_BITS-1:0] mem_rsp_tag
);
  logic busy_q;
  logic [4:0] wait_q;
  logic [MIDX_BITS-1:0] tag_q;
  // whole line fills
  // one fill in flight suffices: the bench waits on every answer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_cmd_accept <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_tag <= 4'h0;
      busy_q <= 1'b0;
      wait_q <= 5'h00;
      tag_q <= 4'h0;
    end else begin
      mem_cmd_accept <= mem_cmd_valid && !mem_cmd_accept;
      mem_rsp_valid <= 1'b0;
      // idle tag is scrambled so a stale value never looks valid
      mem_rsp_tag <= ~mem_rsp_tag;
      if (mem_cmd_valid && mem_cmd_accept && !mem_cmd.write) begin
        busy_q <= 1'b1;
        tag_q <= mem_cmd.tag;
        wait_q <= slow ? 5'h14 : 5'h03;
      end else if (busy_q && wait_q == 5'h00) begin
        busy_q <= 1'b0;
        mem_rsp_valid <= 1'b1;
        mem_rsp_tag <= tag_q;
      end else if (busy_q) begin
        wait_q <= wait_q - 5'h01;
      end
    end
  end
endmodule // l2ap_mem_model
`default_nettype wire

// ---- testbench/l2_cache_alloc_policy_tb_top.sv ----
// l2_cache_alloc_policy_tb_top: self-checking bench for the l2 allocation controller
`timescale 1ns/100ps
`default_nettype none
module l2_cache_alloc_policy_tb_top import l2ap_pkg::*; ;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, req_valid = 0, slow = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, req_ready, rsp_valid, mem_cmd_valid, mem_cmd_accept, mem_rsp_valid;
  logic [MIDX_BITS-1:0] mem_rsp_tag;
  l2ap_req_t req = '0;
  l2ap_rsp_t rsp, rl;
  l2ap_mcmd_t mem_cmd, ml;
  int fails = 0, compares = 0, cyc = 0, mn = 0, dm, lat;
  l2ap_core l2ap_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .mem_cmd_valid(mem_cmd_valid),
    .mem_cmd(mem_cmd), .mem_cmd_accept(mem_cmd_accept), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_tag(mem_rsp_tag));
  l2ap_mem_model l2ap_mem_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .mem_cmd_valid(mem_cmd_valid), .mem_cmd(mem_cmd), .mem_cmd_accept(mem_cmd_accept),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_tag(mem_rsp_tag));
  always #2 core_clk = ~core_clk;
  task final_report;
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      final_report();
    end
    if (mem_cmd_valid && mem_cmd_accept) begin
      mn <= mn + 1;
      ml <= mem_cmd;
    end
  end
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task txn(input logic [31:0] a, input logic w, f, input logic [2:0] c, input logic h, io);
    int m0;
    m0 = mn;
    @(posedge core_clk);
    req_valid <= 1;
    req <= '{addr:a, write:w, full_line:f, request_cache_type:c, core_alloc_hint:h,
      from_io:io, io_partial_alloc_req:io, id:4'h5};
    do begin @(posedge core_clk); end while (req_ready !== 1'b1);
    req_valid <= 0;
    lat = 0;
    do begin @(posedge core_clk); lat++; end while (rsp_valid !== 1'b1);
    rl = rsp;
    dm = mn - m0;
  endtask
  task s_regs;
    apb(0, REG_CTRL, 0); chk(rd === CTRL_RESET, "ctrl reset");
    apb(1, REG_CTRL, 32'hffff_ffff); apb(0, REG_CTRL, 0); chk(rd === CTRL_MASK, "ctrl bits");
    apb(0, REG_STATUS, 0); chk(rd === {21'h0_0000, ECC_EN, LINE64, 1'b1, 8'h00}, "status");
    apb(0, 12'h010, 0); chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped");
    // all ram stalls at their maximum for the traffic that follows
    apb(1, REG_CTRL, 32'h0000_3f00);
  endtask
  task s_read;
    txn(32'h0000_1010, 0, 1, CCA_WB, 0, 0);
    chk(dm == 1 && ml.write === 0 && ml.beats === BURST_BEATS, "fill cmd");
    chk(ml.addr === 32'h0000_1000 && rl.id === 4'h5 && rl.mem_dropped === 0, "fill line");
    chk(rl.hit === 0 && rl.alloc === 1, "read miss");
    txn(32'h0000_1000, 0, 1, CCA_WB, 1, 0); chk(dm == 0 && rl.hit === 1, "read hit");
    // nine lookup cycles, four data cycles, then the response slot
    chk(lat == 15, "stalled hit latency");
    apb(0, REG_HITS, 0); chk(rd === 32'h0000_0001, "hit count");
    apb(0, REG_MISSES, 0); chk(rd === 32'h0000_0001, "miss count");
  endtask
  task s_write;
    txn(32'h0000_1000, 1, 1, CCA_WB, 0, 0); chk(dm == 0 && rl.hit === 1, "full hit");
    txn(32'h0000_2000, 1, 1, CCA_WB, 1, 0);
    chk(dm == 1 && ml.write === 1 && rl.alloc === 0, "full miss");
    txn(32'h0000_1000, 1, 0, CCA_WT, 0, 0);
    chk(dm == 1 && ml.write === 1 && rl.hit === 1, "wt hit");
    txn(32'h0000_2040, 1, 0, CCA_WB, 1, 0); chk(dm == 1 && rl.alloc === 0, "partial");
  endtask
  task s_io;
    slow <= 1;
    apb(1, REG_CTRL, 32'h00ff_3f00);
    txn(32'h0000_3000, 1, 0, CCA_WB, 0, 1);
    chk(dm == 1 && ml.write === 1 && rl.alloc === 0, "all ways locked");
    apb(1, REG_CTRL, 32'h0000_3f00);
    txn(32'h0000_3000, 1, 0, CCA_WB, 0, 1);
    chk(dm == 1 && ml.write === 0 && ml.beats === BURST_BEATS && rl.alloc === 1, "io alloc");
    // the slow fill is still out, so the other half merges into it
    txn(32'h0000_3020, 1, 0, CCA_WB, 0, 1); chk(dm == 0 && rl.id === 4'h5, "merge");
    apb(1, REG_CTRL, 32'h0000_0002);
    txn(32'h0000_4000, 1, 0, CCA_WB, 0, 1); chk(rl.alloc === 0, "override");
  endtask
  task s_bypass;
    apb(1, REG_CTRL, 32'h0000_0001);
    slow <= 1;
    txn(32'h0000_1000, 0, 1, CCA_WB, 0, 0);
    chk(dm == 1 && rl.hit === 0 && ml.beats === SINGLE_BEAT && rl.mem_dropped === 0, "bypass");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
    s_regs();
    s_read();
    s_write();
    s_io();
    s_bypass();
    final_report();
  end
endmodule // l2_cache_alloc_policy_tb_top
`default_nettype wire
